// ### rius_defines.svh
`ifndef RIUS_DEFINES_SVH
`define RIUS_DEFINES_SVH

// Register offsets
`define RIUS_ADDR_TYPE_ID 7'h00
`define RIUS_ADDR_VERSION_ID 7'h01
`define RIUS_ADDR_STATE_FLAGS 7'h02
`define RIUS_ADDR_EVENT_FLAGS 7'h03
`define RIUS_ADDR_CARRIER_LOW 7'h77
`define RIUS_ADDR_MISC 7'h78
`define RIUS_ADDR_HOP_CHAN 7'h79
`define RIUS_ADDR_HOP_STEP 7'h7a
`define RIUS_ADDR_TURNAROUND 7'h7b
`define RIUS_ADDR_TX_HIGH 7'h7c
`define RIUS_ADDR_TX_LOW 7'h7d
`define RIUS_ADDR_RX_HIGH 7'h7e
`define RIUS_ADDR_DATA_PORT 7'h7f

// Reset values
`define RIUS_RST_CARRIER_LOW 8'h80
`define RIUS_RST_MISC 8'h09
`define RIUS_RST_HOP_CHAN 8'h00
`define RIUS_RST_HOP_STEP 8'h00
`define RIUS_RST_TURNAROUND 8'h09
`define RIUS_RST_TX_HIGH 6'h37
`define RIUS_RST_TX_LOW 6'h04
`define RIUS_RST_RX_HIGH 6'h37

// Writable bits; reserved bits read zero after a write
`define RIUS_MASK_MISC 8'h0f
`define RIUS_MASK_TURNAROUND 8'h87

// Event flag bit positions
`define RIUS_EV_FIFO_ERR 7
`define RIUS_EV_TX_HIGH 6
`define RIUS_EV_TX_LOW 5
`define RIUS_EV_RX_HIGH 4
`define RIUS_EV_EXT 3
`define RIUS_EV_PKT_SENT 2
`define RIUS_EV_PKT_RCVD 1
`define RIUS_EV_CRC_FAIL 0

// Device state flag bit positions
`define RIUS_ST_OVERFLOW 7
`define RIUS_ST_UNDERFLOW 6
`define RIUS_ST_RX_EMPTY 5
`define RIUS_ST_HDR_ERR 4

`endif

// ### rius_pkg.sv
package rius_pkg;

   typedef enum logic [1:0] {
      RIUS_PWR_IDLE = 2'b00,
      RIUS_PWR_RX = 2'b01,
      RIUS_PWR_TX = 2'b10
   } rius_pwr_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } rius_reg_req_t;

   typedef struct packed {
      logic tx_start;
      logic pkt_sent;
      logic fifo_mode;
      logic rx_start;
      logic sync_ok;
      logic pkt_rx_ok;
      logic crc_fail;
      logic header_err;
   } rius_radio_ev_t;

endpackage

// ### rius_mem.sv
`timescale 1ns/10ps
module rius_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 64,
   parameter int AW = 6
) (
   // Clock
   input wire logic clk_in,
   // Write side
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   // Read side
   input wire logic [AW-1:0] rd_addr_in,
   output logic [WIDTH-1:0] rd_data_out
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   // Read during write of the same word returns the old word
   always_ff @(posedge clk_in) begin
      rd_data_out <= mem[rd_addr_in];
   end
endmodule // rius_mem

// ### rius_sync3.sv
`timescale 1ns/10ps
module rius_sync3 (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Asynchronous level and its filtered copy
   input wire logic async_in,
   output logic level_out
);
   logic ff1;
   logic ff2;
   logic ff3;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ff1 <= 1'b0;
         ff2 <= 1'b0;
         ff3 <= 1'b0;
      end else begin
         ff1 <= async_in;
         ff2 <= ff1;
         ff3 <= ff2;
      end
   end

   // A change counts only once two stages agree
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         level_out <= 1'b0;
      end else if (ff2 == ff3) begin
         level_out <= ff3;
      end
   end
endmodule // rius_sync3

// ### rius_top.sv
`timescale 1ns/10ps
`include "rius_defines.svh"

module rius_top
   import rius_pkg::*;
#(
   parameter int DEPTH = 64,
   parameter int AW = 6,
   // Arbitrary identity values
   parameter logic [4:0] TYPE_CODE = 5'h15,
   parameter logic [4:0] VERSION_CODE = 5'h0a
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Host register port
   input wire rius_pkg::rius_reg_req_t reg_req_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   // Interrupt enables and alert line
   input wire logic [7:0] irq_enable_in,
   output logic host_alert_line_low_out,
   // Radio core
   input wire rius_pkg::rius_radio_ev_t radio_ev_in,
   input wire rius_pkg::rius_pwr_t power_state_in,
   input wire logic tx_fifo_rst_in,
   input wire logic rx_fifo_rst_in,
   input wire logic tx_pop_in,
   output logic [7:0] tx_byte_out,
   input wire logic rx_push_in,
   input wire logic [7:0] rx_byte_in,
   // GPIO interrupt source pin
   input wire logic gpio_irq_pin_in
);
   import rius_pkg::*;

   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

   logic [7:0] carrier_freq_low, misc_settings, hop_channel_select;
   logic [7:0] hop_step_size, turnaround_length_ctrl;
   logic [5:0] tx_fill_high_level, tx_fill_low_level, rx_fill_high_level;
   logic [7:0] event_flags_primary, flags_prev, set_evt, clr_cond;
   logic [7:0] rd_hold, rx_q, next_rd_hold;
   logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
   logic [AW:0] tx_cnt, rx_cnt;
   logic tx_ovf, tx_unf, rx_ovf, rx_unf;
   logic tx_high_q, tx_low_q, rx_high_q, rx_high_lvl;
   logic gpio_lvl, gpio_q, fifo_mode_q, rd_pend, rd_fifo;
   logic host_wr_data, host_rd_data, stat_rd;
   logic tx_push, tx_pop, rx_push, rx_pop;
   logic tx_high_lvl, tx_low_lvl, err_evt, any_rise;

   assign host_wr_data = reg_req_in.wr &&
      reg_req_in.addr == `RIUS_ADDR_DATA_PORT;
   assign host_rd_data = reg_req_in.rd &&
      reg_req_in.addr == `RIUS_ADDR_DATA_PORT;
   assign stat_rd = reg_req_in.rd &&
      reg_req_in.addr == `RIUS_ADDR_EVENT_FLAGS;
   assign tx_push = host_wr_data && tx_cnt != FULL_COUNT;
   assign tx_pop = tx_pop_in && tx_cnt != '0;
   assign rx_push = rx_push_in && rx_cnt != FULL_COUNT;
   assign rx_pop = host_rd_data && rx_cnt != '0;
   assign err_evt = (host_wr_data && tx_cnt == FULL_COUNT) ||
      (tx_pop_in && tx_cnt == '0) ||
      (rx_push_in && rx_cnt == FULL_COUNT) ||
      (host_rd_data && rx_cnt == '0);
   assign tx_high_lvl = tx_cnt > {1'b0, tx_fill_high_level};
   assign tx_low_lvl = tx_cnt <= {1'b0, tx_fill_low_level};

   // Receive high level holds at equality, giving a one-byte hysteresis
   always_comb begin
      if (rx_cnt > {1'b0, rx_fill_high_level}) begin
         rx_high_lvl = 1'b1;
      end else if (rx_cnt < {1'b0, rx_fill_high_level}) begin
         rx_high_lvl = 1'b0;
      end else begin
         rx_high_lvl = rx_high_q;
      end
   end

   rius_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_tx_mem (
      .clk_in(clk_in),
      .wr_en_in(tx_push),
      .wr_addr_in(tx_wp),
      .wr_data_in(reg_req_in.wdata),
      .rd_addr_in(tx_rp),
      .rd_data_out(tx_byte_out)
   );

   rius_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_rx_mem (
      .clk_in(clk_in),
      .wr_en_in(rx_push),
      .wr_addr_in(rx_wp),
      .wr_data_in(rx_byte_in),
      .rd_addr_in(rx_rp),
      .rd_data_out(rx_q)
   );

   rius_sync3 u_gpio_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .async_in(gpio_irq_pin_in),
      .level_out(gpio_lvl)
   );

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_wp <= '0;
         tx_rp <= '0;
         tx_cnt <= '0;
      end else if (tx_fifo_rst_in) begin
         tx_wp <= '0;
         tx_rp <= '0;
         tx_cnt <= '0;
      end else begin
         if (tx_push) begin
            tx_wp <= tx_wp + 1'b1;
         end
         if (tx_pop) begin
            tx_rp <= tx_rp + 1'b1;
         end
         tx_cnt <= tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_wp <= '0;
         rx_rp <= '0;
         rx_cnt <= '0;
      end else if (rx_fifo_rst_in) begin
         rx_wp <= '0;
         rx_rp <= '0;
         rx_cnt <= '0;
      end else begin
         if (rx_push) begin
            rx_wp <= rx_wp + 1'b1;
         end
         if (rx_pop) begin
            rx_rp <= rx_rp + 1'b1;
         end
         rx_cnt <= rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
      end
   end

   // Sticky per-FIFO error bits; a new error beats a reset
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_ovf <= 1'b0;
         tx_unf <= 1'b0;
         rx_ovf <= 1'b0;
         rx_unf <= 1'b0;
      end else begin
         tx_ovf <= (host_wr_data && tx_cnt == FULL_COUNT) ||
            (tx_ovf && !tx_fifo_rst_in);
         tx_unf <= (tx_pop_in && tx_cnt == '0) ||
            (tx_unf && !tx_fifo_rst_in);
         rx_ovf <= (rx_push_in && rx_cnt == FULL_COUNT) ||
            (rx_ovf && !rx_fifo_rst_in);
         rx_unf <= (host_rd_data && rx_cnt == '0) ||
            (rx_unf && !rx_fifo_rst_in);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_high_q <= 1'b0;
         tx_low_q <= 1'b0;
         rx_high_q <= 1'b0;
         gpio_q <= 1'b0;
         fifo_mode_q <= 1'b0;
      end else begin
         tx_high_q <= tx_high_lvl;
         tx_low_q <= tx_low_lvl;
         rx_high_q <= rx_high_lvl;
         gpio_q <= gpio_lvl;
         fifo_mode_q <= radio_ev_in.fifo_mode;
      end
   end

   // Enabled level flags latch on the rising level only, else a clearing
   // read would be undone at once while the level stands
   always_comb begin
      set_evt = '0;
      clr_cond = '0;
      set_evt[`RIUS_EV_FIFO_ERR] = err_evt;
      clr_cond[`RIUS_EV_FIFO_ERR] = (tx_fifo_rst_in || rx_fifo_rst_in) &&
         (tx_fifo_rst_in || !(tx_ovf || tx_unf)) &&
         (rx_fifo_rst_in || !(rx_ovf || rx_unf));
      set_evt[`RIUS_EV_TX_HIGH] = irq_enable_in[`RIUS_EV_TX_HIGH] ?
         (tx_high_lvl && !tx_high_q) : tx_high_lvl;
      clr_cond[`RIUS_EV_TX_HIGH] = !tx_high_lvl;
      set_evt[`RIUS_EV_TX_LOW] = irq_enable_in[`RIUS_EV_TX_LOW] ?
         (tx_low_lvl && !tx_low_q) : tx_low_lvl;
      clr_cond[`RIUS_EV_TX_LOW] = !tx_low_lvl;
      set_evt[`RIUS_EV_RX_HIGH] = irq_enable_in[`RIUS_EV_RX_HIGH] ?
         (rx_high_lvl && !rx_high_q) : rx_high_lvl;
      clr_cond[`RIUS_EV_RX_HIGH] = !rx_high_lvl;
      set_evt[`RIUS_EV_EXT] = gpio_lvl && !gpio_q;
      set_evt[`RIUS_EV_PKT_SENT] = radio_ev_in.pkt_sent;
      clr_cond[`RIUS_EV_PKT_SENT] = radio_ev_in.tx_start ||
         (fifo_mode_q && !radio_ev_in.fifo_mode);
      set_evt[`RIUS_EV_PKT_RCVD] = radio_ev_in.pkt_rx_ok;
      clr_cond[`RIUS_EV_PKT_RCVD] = radio_ev_in.sync_ok;
      set_evt[`RIUS_EV_CRC_FAIL] = radio_ev_in.crc_fail;
      clr_cond[`RIUS_EV_CRC_FAIL] = radio_ev_in.rx_start;
   end

   // Set always beats any clear in the same cycle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         event_flags_primary <= '0;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (set_evt[i]) begin
               event_flags_primary[i] <= 1'b1;
            end else if (stat_rd && irq_enable_in[i]) begin
               event_flags_primary[i] <= 1'b0;
            end else if (!irq_enable_in[i] && clr_cond[i]) begin
               event_flags_primary[i] <= 1'b0;
            end
         end
      end
   end

   assign any_rise = |(event_flags_primary & ~flags_prev & irq_enable_in);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flags_prev <= '0;
         host_alert_line_low_out <= 1'b1;
      end else begin
         // A flag set again during its clearing read counts as a new rise
         flags_prev <= stat_rd ? (event_flags_primary & ~irq_enable_in) :
            event_flags_primary;
         if (stat_rd) begin
            host_alert_line_low_out <= 1'b1;
         end else if (any_rise) begin
            host_alert_line_low_out <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         carrier_freq_low <= `RIUS_RST_CARRIER_LOW;
         misc_settings <= `RIUS_RST_MISC;
         hop_channel_select <= `RIUS_RST_HOP_CHAN;
         hop_step_size <= `RIUS_RST_HOP_STEP;
         turnaround_length_ctrl <= `RIUS_RST_TURNAROUND;
         tx_fill_high_level <= `RIUS_RST_TX_HIGH;
         tx_fill_low_level <= `RIUS_RST_TX_LOW;
         rx_fill_high_level <= `RIUS_RST_RX_HIGH;
      end else if (reg_req_in.wr) begin
         case (reg_req_in.addr)
            `RIUS_ADDR_CARRIER_LOW: carrier_freq_low <= reg_req_in.wdata;
            `RIUS_ADDR_MISC: begin
               misc_settings <= reg_req_in.wdata & `RIUS_MASK_MISC;
            end
            `RIUS_ADDR_HOP_CHAN: hop_channel_select <= reg_req_in.wdata;
            `RIUS_ADDR_HOP_STEP: hop_step_size <= reg_req_in.wdata;
            `RIUS_ADDR_TURNAROUND: begin
               turnaround_length_ctrl <=
                  reg_req_in.wdata & `RIUS_MASK_TURNAROUND;
            end
            `RIUS_ADDR_TX_HIGH: tx_fill_high_level <= reg_req_in.wdata[5:0];
            `RIUS_ADDR_TX_LOW: tx_fill_low_level <= reg_req_in.wdata[5:0];
            `RIUS_ADDR_RX_HIGH: rx_fill_high_level <= reg_req_in.wdata[5:0];
            default: ;
         endcase
      end
   end

   // Snapshot taken in the read cycle, so flags read before they clear
   always_comb begin
      next_rd_hold = 8'h00;
      case (reg_req_in.addr)
         `RIUS_ADDR_TYPE_ID: next_rd_hold = {3'h0, TYPE_CODE};
         `RIUS_ADDR_VERSION_ID: next_rd_hold = {3'h0, VERSION_CODE};
         `RIUS_ADDR_STATE_FLAGS: begin
            next_rd_hold[`RIUS_ST_OVERFLOW] = tx_ovf || rx_ovf;
            next_rd_hold[`RIUS_ST_UNDERFLOW] = tx_unf || rx_unf;
            next_rd_hold[`RIUS_ST_RX_EMPTY] = rx_cnt == '0;
            next_rd_hold[`RIUS_ST_HDR_ERR] = radio_ev_in.header_err;
            next_rd_hold[1:0] = power_state_in;
         end
         `RIUS_ADDR_EVENT_FLAGS: next_rd_hold = event_flags_primary;
         `RIUS_ADDR_CARRIER_LOW: next_rd_hold = carrier_freq_low;
         `RIUS_ADDR_MISC: next_rd_hold = misc_settings;
         `RIUS_ADDR_HOP_CHAN: next_rd_hold = hop_channel_select;
         `RIUS_ADDR_HOP_STEP: next_rd_hold = hop_step_size;
         `RIUS_ADDR_TURNAROUND: next_rd_hold = turnaround_length_ctrl;
         `RIUS_ADDR_TX_HIGH: next_rd_hold = {2'h0, tx_fill_high_level};
         `RIUS_ADDR_TX_LOW: next_rd_hold = {2'h0, tx_fill_low_level};
         `RIUS_ADDR_RX_HIGH: next_rd_hold = {2'h0, rx_fill_high_level};
         default: next_rd_hold = 8'h00;
      endcase
   end

   // Two-cycle read path covers the registered FIFO memory output
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_pend <= 1'b0;
         rd_fifo <= 1'b0;
         rd_hold <= 8'h00;
         reg_rdata_out <= 8'h00;
         reg_rvalid_out <= 1'b0;
      end else begin
         rd_pend <= reg_req_in.rd;
         rd_fifo <= host_rd_data;
         if (reg_req_in.rd) begin
            rd_hold <= next_rd_hold;
         end
         reg_rvalid_out <= rd_pend;
         if (rd_pend) begin
            reg_rdata_out <= rd_fifo ? rx_q : rd_hold;
         end
      end
   end
endmodule // rius_top

// ### rius_top_assertions.sv
`timescale 1ns/10ps
module rius_checker
   import rius_pkg::*;
#(
   parameter logic [4:0] TYPE_CODE = 5'h15,
   parameter logic [4:0] VERSION_CODE = 5'h0a
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Register port and alert
   input wire rius_pkg::rius_reg_req_t reg_req_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic reg_rvalid_out,
   input wire logic [7:0] irq_enable_in,
   input wire logic host_alert_line_low_out,
   // Radio core
   input wire rius_pkg::rius_radio_ev_t radio_ev_in,
   input wire rius_pkg::rius_pwr_t power_state_in,
   input wire logic tx_pop_in,
   input wire logic rx_push_in,
   input wire logic tx_fifo_rst_in,
   input wire logic rx_fifo_rst_in
);
   logic rd_flags;
   logic quiet;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   assign rd_flags = reg_req_in.rd && reg_req_in.addr == 7'h03;
   // No radio pulse, FIFO strobe or reset, or register write this cycle
   assign quiet = radio_ev_in[7:6] == 2'b00 && radio_ev_in[4:1] == 4'h0 &&
      !tx_pop_in && !rx_push_in && !reg_req_in.wr && !tx_fifo_rst_in &&
      !rx_fifo_rst_in;
   chk_read_answer: assert property (reg_req_in.rd |-> ##2 reg_rvalid_out)
      else $error("read answer missing");
   chk_answer_cause: assert property (reg_rvalid_out |-> $past(reg_req_in.rd, 2))
      else $error("answer without read");
   chk_type_code: assert property (reg_req_in.rd && reg_req_in.addr == 7'h00
      |-> ##2 reg_rdata_out == {3'h0, TYPE_CODE})
      else $error("type code wrong");
   chk_version_code: assert property (reg_req_in.rd && reg_req_in.addr == 7'h01
      |-> ##2 reg_rdata_out == {3'h0, VERSION_CODE})
      else $error("version code wrong");
   chk_state_bits: assert property (reg_req_in.rd && reg_req_in.addr == 7'h02
      |-> ##2 reg_rdata_out[4:0] == {$past(radio_ev_in.header_err, 2),
      2'b00, $past(power_state_in, 2)})
      else $error("state bits wrong");
   chk_alert_rise: assert property (radio_ev_in.pkt_sent && irq_enable_in[2]
      && !rd_flags ##1 !rd_flags && $stable(irq_enable_in)
      |=> !host_alert_line_low_out)
      else $error("alert not driven low");
   chk_read_release: assert property (rd_flags && quiet && $past(quiet)
      |=> host_alert_line_low_out)
      else $error("alert not released");
   chk_alert_hold: assert property (!host_alert_line_low_out && !rd_flags
      && $stable(irq_enable_in) |=> !host_alert_line_low_out)
      else $error("alert released early");
   chk_alert_cause: assert property ($fell(host_alert_line_low_out)
      |-> $past(irq_enable_in) != 8'h00)
      else $error("alert with no enable");
   cov_alert_drop: cover property ($fell(host_alert_line_low_out));
   cov_flag_read: cover property (rd_flags && !host_alert_line_low_out);
   cov_port_read: cover property (reg_req_in.rd && reg_req_in.addr == 7'h7f);
endmodule // rius_checker

bind rius_top rius_checker #(.TYPE_CODE(TYPE_CODE),
   .VERSION_CODE(VERSION_CODE)) u_rius_checker (.clk_in(clk_in),
   .rst_n_in(rst_n_in), .reg_req_in(reg_req_in),
   .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
   .irq_enable_in(irq_enable_in),
   .host_alert_line_low_out(host_alert_line_low_out),
   .radio_ev_in(radio_ev_in), .power_state_in(power_state_in),
   .tx_pop_in(tx_pop_in), .rx_push_in(rx_push_in),
   .tx_fifo_rst_in(tx_fifo_rst_in), .rx_fifo_rst_in(rx_fifo_rst_in));

// ### rius_host_model.sv
`timescale 1ns/10ps
module rius_host_model
   import rius_pkg::*;
(
   // Clock
   input wire logic clk_in,
   // Register port
   output rius_pkg::rius_reg_req_t req_out,
   input wire logic [7:0] rdata_in,
   input wire logic rvalid_in
);
   initial req_out = '0;
   // Released lines invert so a stale address never looks valid
   task automatic idle();
      req_out <= '{1'b0, 1'b0, ~req_out.addr, ~req_out.wdata};
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_in);
      req_out <= '{1'b0, 1'b1, a, d};
      @(posedge clk_in);
      idle();
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      int n;
      @(posedge clk_in);
      req_out <= '{1'b1, 1'b0, a, ~req_out.wdata};
      @(posedge clk_in);
      idle();
      for (n = 0; n < 6; n++) begin
         @(negedge clk_in);
         if (rvalid_in === 1'b1) break;
      end
      // A missing answer reads as unknown so the compare fails
      d = (rvalid_in === 1'b1) ? rdata_in : 8'hxx;
   endtask
endmodule // rius_host_model

// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import rius_pkg::*;
   localparam logic [4:0] TCODE = 5'h0c; // Arbitrary value
   localparam logic [4:0] VCODE = 5'h13; // Arbitrary value
   localparam logic [7:0] RSTV [8] = '{8'h80, 8'h09, 8'h00, 8'h00, 8'h09,
      8'h37, 8'h04, 8'h37};
   localparam logic [7:0] MASK [8] = '{8'hff, 8'h0f, 8'hff, 8'hff, 8'h87,
      8'h3f, 8'h3f, 8'h3f};
   localparam int SETI [3] = '{6, 2, 1};
   localparam int CLRI [3] = '{7, 3, 4};
   logic clk_in, alert_low, rvalid, ferr = 0, ovf = 0, unf = 0, rxhi = 0;
   logic rst_n_in = 0, gpio = 0;
   logic [7:0] rdata, tx_byte, d, v, irq_en = 0, rx_byte = 0;
   logic [11:0] strb = 0;
   logic [6:0] a;
   logic [3:0] evf = 0;
   logic [31:0] seed = 32'd10374;
   logic [7:0] txq[$], rxq[$];
   rius_reg_req_t req;
   rius_pwr_t pwr = RIUS_PWR_IDLE;
   int txh, txl, rxh, i, errors = 0, checked = 0, cycles = 0;
   rius_top #(.TYPE_CODE(TCODE), .VERSION_CODE(VCODE)) DUT (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(req),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .irq_enable_in(irq_en),
      .host_alert_line_low_out(alert_low),
      .radio_ev_in(rius_radio_ev_t'(strb[7:0])), .power_state_in(pwr),
      .tx_fifo_rst_in(strb[10]), .rx_fifo_rst_in(strb[11]),
      .tx_pop_in(strb[8]), .tx_byte_out(tx_byte), .rx_push_in(strb[9]),
      .rx_byte_in(rx_byte), .gpio_irq_pin_in(gpio));
   rius_host_model host (.clk_in(clk_in), .req_out(req), .rdata_in(rdata),
      .rvalid_in(rvalid));
   function logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   function logic [7:0] expf();
      return {ferr, txq.size() > txh, txq.size() <= txl, rxhi, evf};
   endfunction
   function logic [7:0] exps();
      return {ovf, unf, rxq.size() == 0, strb[0], 2'b00, pwr};
   endfunction
   task automatic check(input string s, input logic [7:0] e,
      input logic [7:0] g);
      checked++;
      if (g !== e) begin
         $display("unexpected %s: expected %h, seen %h", s, e, g);
         errors++;
      end
   endtask
   task automatic rdchk(input logic [6:0] ad, input logic [7:0] e,
      input string s);
      host.rd(ad, d);
      check(s, e, d);
      // Model clears only enabled flags on a flag read
      if (ad == 7'h03) evf = evf & ~irq_en[3:0];
   endtask
   task automatic pulse(input int k);
      @(posedge clk_in);
      strb[k] <= 1'b1;
      @(posedge clk_in);
      strb[k] <= 1'b0;
      repeat (2) @(posedge clk_in);
   endtask
   task automatic rxupd();
      if (rxq.size() > rxh) rxhi = 1'b1;
      else if (rxq.size() < rxh) rxhi = 1'b0;
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         results();
      end
   end
   initial begin
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1'b1;
      strb[5] <= 1'b1;
      for (a = 7'h77; a != 7'h7f; a++) begin
         rdchk(a, RSTV[a - 7'h77], "config reset");
         v = rnd();
         host.wr(a, v);
         rdchk(a, v & MASK[a - 7'h77], "config rw");
      end
      host.wr(7'h7c, 8'h03);
      host.wr(7'h7d, 8'h01);
      host.wr(7'h7e, 8'h02);
      txh = 3;
      txl = 1;
      rxh = 2;
      host.wr(7'h10, 8'hff);
      rdchk(7'h10, 8'h00, "unmapped");
      host.wr(7'h00, 8'hff);
      rdchk(7'h00, {3'h0, TCODE}, "type id");
      rdchk(7'h01, {3'h0, VCODE}, "version id");
      for (i = 0; i < 3; i++) begin
         @(posedge clk_in);
         pwr <= rius_pwr_t'(i);
         strb[0] <= ~i[0];
         @(posedge clk_in);
         rdchk(7'h02, exps(), "state flags");
      end
      for (i = 0; i < 3; i++) begin
         pulse(SETI[i]);
         evf[2 - i] = 1'b1;
         rdchk(7'h03, expf(), "event set");
         pulse(CLRI[i]);
         evf[2 - i] = 1'b0;
         rdchk(7'h03, expf(), "event clear");
      end
      pulse(6);
      strb[5] <= 1'b0;
      rdchk(7'h03, expf(), "fifo mode exit");
      @(posedge clk_in);
      strb[5] <= 1'b1;
      for (i = 0; i < 65; i++) begin
         v = rnd();
         host.wr(7'h7f, v);
         if (txq.size() < 64) txq.push_back(v);
         else {ovf, ferr} = 2'b11;
         rdchk(7'h03, expf(), "tx fill flags");
      end
      rdchk(7'h02, exps(), "tx overflow");
      while (txq.size() > 0) begin
         @(negedge clk_in);
         check("tx head", txq.pop_front(), tx_byte);
         pulse(8);
         rdchk(7'h03, expf(), "tx drain flags");
      end
      pulse(10);
      {ovf, ferr} = 2'b00;
      rdchk(7'h03, expf(), "tx reset flags");
      for (i = 0; i < 5; i++) begin
         @(posedge clk_in);
         rx_byte <= rnd();
         pulse(9);
         rxq.push_back(rx_byte);
         rxupd();
         rdchk(7'h03, expf(), "rx fill flags");
      end
      for (i = 0; i < 6; i++) begin
         if (rxq.size() > 0) v = rxq.pop_front();
         else {unf, ferr} = 2'b11;
         host.rd(7'h7f, d);
         if (i < 5) check("rx data", v, d);
         rxupd();
         rdchk(7'h03, expf(), "rx drain flags");
      end
      rdchk(7'h02, exps(), "rx underflow");
      pulse(11);
      {unf, ferr} = 2'b00;
      rdchk(7'h03, expf(), "rx reset flags");
      @(posedge clk_in);
      irq_en <= 8'h05;
      pulse(6);
      evf[2] = 1'b1;
      check("alert on event", 8'h00, {7'h0, alert_low});
      pulse(1);
      evf[0] = 1'b1;
      check("alert held", 8'h00, {7'h0, alert_low});
      rdchk(7'h03, expf(), "enabled flags");
      check("alert released", 8'h01, {7'h0, alert_low});
      rdchk(7'h03, expf(), "after clearing read");
      pulse(6);
      evf[2] = 1'b1;
      check("alert again", 8'h00, {7'h0, alert_low});
      rdchk(7'h03, expf(), "second read");
      @(posedge clk_in);
      irq_en <= 8'h08;
      gpio <= 1'b1;
      for (i = 0; i < 10 && alert_low !== 1'b0; i++) @(negedge clk_in);
      evf[3] = 1'b1;
      check("gpio alert", 8'h00, {7'h0, alert_low});
      rdchk(7'h03, expf(), "gpio flag");
      results();
   end
endmodule // tb_top
